// *** output_select_map.vh ***
// Function codes, field positions, reset values and timing counts for the output selector.
`ifndef OUTPUT_SELECT_MAP_VH
`define OUTPUT_SELECT_MAP_VH

`define FN_UNUSED 6'h00
`define FN_REF_ABOVE 6'h01
`define FN_SPEED_ABOVE 6'h02
`define FN_SPEED_BELOW 6'h03
`define FN_AT_REF 6'h04
`define FN_ZERO_SPEED 6'h05
`define FN_CUR_ABOVE 6'h06
`define FN_CUR_BELOW 6'h07
`define FN_TORQ_ABOVE 6'h08
`define FN_TORQ_BELOW 6'h09
`define FN_REMOTE 6'h0A
`define FN_RUN 6'h0B
`define FN_READY 6'h0C
`define FN_NO_FAULT 6'h0D
`define FN_NO_GRP0 6'h0E
`define FN_NO_GRP1 6'h0F
`define FN_NO_GRP2 6'h10
`define FN_NO_GRP3 6'h11
`define FN_NO_GRP4 6'h12
`define FN_LOOP_OK 6'h13
`define FN_NETWORK 6'h14
`define FN_FORWARD 6'h15
`define FN_RIDE_THRU 6'h18
`define FN_PRECHARGE 6'h19
`define FN_FAULT 6'h1A
`define FN_TIMER 6'h1D
`define FN_SPEED_AND_REF 6'h1E
`define FN_FREQ_ABOVE1 6'h1F
`define FN_FREQ_ABOVE2 6'h20
`define FN_STO 6'h21
`define FN_NO_GRP5 6'h22
`define FN_NO_ALARM 6'h23
`define FN_NO_FAULT_ALARM 6'h24

// Fault group bit positions in the fault vector.
`define GRP_OVERCURRENT 0
`define GRP_OUT_OVERCURRENT 1
`define GRP_SUPPLY 2
`define GRP_PHASE_TEMP 3
`define GRP_MOTOR_OVERLOAD 4
`define GRP_SAFETY_RELAY 5

`define CTRL_TYPE_VEC_A 3'h3
`define CTRL_TYPE_VEC_B 3'h4
`define CTRL_MODE_ENCODER 3'h4

// Reset selections for outputs 1 to 5.
`define RST_SEL_OUT1 6'h0D
`define RST_SEL_OUT2 6'h02
`define RST_SEL_OUT3 6'h01
`define RST_SEL_OUT4 6'h00
`define RST_SEL_OUT5 6'h00

// Delays are in tenths of a second; DELAY_MAX (300.0 s) is not applied to the relay delays.
`define DELAY_UNIT_NS 100000000
`define CLK_PERIOD_NS 10
`define DELAY_TICK_CYCLES (`DELAY_UNIT_NS / `CLK_PERIOD_NS)
`define DELAY_MAX 16'h0BB8
`define SPEED_HYST_MAX 16'h0384
`define ZERO_ZONE_MAX 16'h4650

`endif

// *** output_select.v ***
// Output condition selector with hysteresis comparators and relay timers.
`timescale 1ns/1ps
`default_nettype none
`include "output_select_map.vh"

module output_select #(
	parameter W = 16,
	parameter TICK_CYCLES = `DELAY_TICK_CYCLES
) (
	input wire clk,
	input wire rstn,
	input wire [29:0] func_sel,
	input wire [2:0] control_type_select,
	input wire [2:0] control_mode_select,
	input wire [W-1:0] speed_upper_threshold,
	input wire [W-1:0] speed_lower_threshold,
	input wire [W-1:0] speed_hysteresis,
	input wire [W-1:0] zero_speed_zone,
	input wire [W-1:0] current_threshold,
	input wire [W-1:0] torque_threshold,
	input wire [W-1:0] at_ref_band,
	input wire [W-1:0] freq_threshold,
	input wire [W-1:0] freq_hysteresis,
	input wire [W-1:0] relay2_on_delay,
	input wire [W-1:0] relay2_off_delay,
	input wire [W-1:0] relay3_on_delay,
	input wire [W-1:0] relay3_off_delay,
	input wire [W-1:0] motor_speed,
	input wire [W-1:0] speed_reference,
	input wire [W-1:0] total_reference,
	input wire [W-1:0] motor_current,
	input wire [W-1:0] motor_torque_reading,
	input wire [W-1:0] motor_freq,
	input wire motor_reverse,
	input wire remote_mode,
	input wire drive_enabled,
	input wire undervoltage,
	input wire any_fault,
	input wire [5:0] fault_groups,
	input wire alarm_present,
	input wire loop_current_ok,
	input wire [4:0] network_output_word,
	input wire ride_through,
	input wire precharge_ok,
	input wire safe_torque_off_state,
	input wire relay2_timer_input,
	input wire relay3_timer_input,
	output wire [4:0] output_n
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser for the timer inputs: three stages, change counts once the
// second and third stages agree.

reg [2:0] t2_sync_q;
reg [2:0] t3_sync_q;
reg t2_level_q;
reg t3_level_q;

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		t2_sync_q <= 3'b000;
		t3_sync_q <= 3'b000;
		t2_level_q <= 1'b0;
		t3_level_q <= 1'b0;
	end else begin
		t2_sync_q <= {t2_sync_q[1:0], relay2_timer_input};
		t3_sync_q <= {t3_sync_q[1:0], relay3_timer_input};
		if (t2_sync_q[1] == t2_sync_q[2])
			t2_level_q <= t2_sync_q[2];
		if (t3_sync_q[1] == t3_sync_q[2])
			t3_level_q <= t3_sync_q[2];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Tenth-of-a-second tick shared by both relay timers.

reg [31:0] tick_cnt_q;
reg tick_q;

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		tick_cnt_q <= 32'h0000_0000;
		tick_q <= 1'b0;
	end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
		tick_cnt_q <= 32'h0000_0000;
		tick_q <= 1'b1;
	end else begin
		tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
		tick_q <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Relay timers. The relay follows the input only after the input has held
// its new level for the whole delay; an early reversal restarts the count.

reg r2_q;
reg r3_q;
reg [W-1:0] r2_cnt_q;
reg [W-1:0] r3_cnt_q;
wire [W-1:0] r2_delay = t2_level_q ? relay2_on_delay : relay2_off_delay;
wire [W-1:0] r3_delay = t3_level_q ? relay3_on_delay : relay3_off_delay;

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		r2_q <= 1'b0;
		r2_cnt_q <= {W{1'b0}};
	end else if (t2_level_q == r2_q) begin
		r2_cnt_q <= {W{1'b0}};
	end else if (r2_cnt_q >= r2_delay) begin
		r2_q <= t2_level_q;
		r2_cnt_q <= {W{1'b0}};
	end else if (tick_q) begin
		r2_cnt_q <= r2_cnt_q + 1'b1;
	end
end

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		r3_q <= 1'b0;
		r3_cnt_q <= {W{1'b0}};
	end else if (t3_level_q == r3_q) begin
		r3_cnt_q <= {W{1'b0}};
	end else if (r3_cnt_q >= r3_delay) begin
		r3_q <= t3_level_q;
		r3_cnt_q <= {W{1'b0}};
	end else if (tick_q) begin
		r3_cnt_q <= r3_cnt_q + 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Hysteresis comparators. The lower edge saturates at zero so that a band
// wider than the threshold never wraps round.

reg spd_above_q;
reg spd_below_q;
reg freq_above_q;
wire [W-1:0] hyst_sp = (speed_hysteresis > `SPEED_HYST_MAX) ?
	`SPEED_HYST_MAX : speed_hysteresis;
wire [W-1:0] up_low = (speed_upper_threshold > hyst_sp) ?
	speed_upper_threshold - hyst_sp : {W{1'b0}};
wire [W:0] lo_high = {1'b0, speed_lower_threshold} + {1'b0, hyst_sp};
wire [W-1:0] fx_low = (freq_threshold > freq_hysteresis) ?
	freq_threshold - freq_hysteresis : {W{1'b0}};

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		spd_above_q <= 1'b0;
		spd_below_q <= 1'b0;
		freq_above_q <= 1'b0;
	end else begin
		if (motor_speed > speed_upper_threshold)
			spd_above_q <= 1'b1;
		else if (motor_speed < up_low)
			spd_above_q <= 1'b0;
		// Speed-below mirrors the band above the lower threshold.
		if (motor_speed < speed_lower_threshold)
			spd_below_q <= 1'b1;
		else if ({1'b0, motor_speed} > lo_high)
			spd_below_q <= 1'b0;
		if (motor_freq > freq_threshold)
			freq_above_q <= 1'b1;
		else if (motor_freq < fx_low)
			freq_above_q <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Condition evaluation.

wire torque_ok = (control_type_select == `CTRL_TYPE_VEC_A) ||
	(control_type_select == `CTRL_TYPE_VEC_B);
wire [W-1:0] zone = (zero_speed_zone > `ZERO_ZONE_MAX) ?
	`ZERO_ZONE_MAX : zero_speed_zone;
wire [W:0] ref_hi = {1'b0, speed_reference} + {1'b0, at_ref_band};
wire [W-1:0] ref_lo = (speed_reference > at_ref_band) ?
	speed_reference - at_ref_band : {W{1'b0}};
wire at_ref = (motor_speed >= ref_lo) && ({1'b0, motor_speed} <= ref_hi);

function cond;
	input [5:0] sel;
	input timer_q;
	input timer_ok;
	input net_bit;
	begin
		case (sel)
		`FN_REF_ABOVE: cond = speed_reference > speed_upper_threshold;
		`FN_SPEED_ABOVE: cond = spd_above_q;
		`FN_SPEED_BELOW: cond = spd_below_q;
		`FN_AT_REF: cond = at_ref;
		`FN_ZERO_SPEED: cond = motor_speed < zone;
		`FN_CUR_ABOVE: cond = motor_current > current_threshold;
		`FN_CUR_BELOW: cond = motor_current < current_threshold;
		`FN_TORQ_ABOVE: cond = torque_ok &&
			(motor_torque_reading > torque_threshold);
		`FN_TORQ_BELOW: cond = torque_ok &&
			(motor_torque_reading < torque_threshold);
		`FN_REMOTE: cond = remote_mode;
		`FN_RUN: cond = drive_enabled;
		`FN_READY: cond = !drive_enabled && !any_fault &&
			!undervoltage;
		`FN_NO_FAULT: cond = !any_fault;
		`FN_NO_GRP0: cond = !fault_groups[`GRP_OVERCURRENT];
		`FN_NO_GRP1: cond = !fault_groups[`GRP_OUT_OVERCURRENT];
		`FN_NO_GRP2: cond = !fault_groups[`GRP_SUPPLY];
		`FN_NO_GRP3: cond = !fault_groups[`GRP_PHASE_TEMP];
		`FN_NO_GRP4: cond = !fault_groups[`GRP_MOTOR_OVERLOAD];
		`FN_NO_GRP5: cond = !fault_groups[`GRP_SAFETY_RELAY];
		`FN_LOOP_OK: cond = loop_current_ok;
		`FN_NETWORK: cond = net_bit;
		`FN_FORWARD: cond = !motor_reverse;
		`FN_RIDE_THRU: cond = ride_through;
		`FN_PRECHARGE: cond = precharge_ok;
		`FN_FAULT: cond = any_fault;
		`FN_TIMER: cond = timer_ok && timer_q;
		`FN_SPEED_AND_REF: cond =
			(control_mode_select == `CTRL_MODE_ENCODER) &&
			(motor_speed > speed_upper_threshold) &&
			(total_reference > speed_upper_threshold);
		`FN_FREQ_ABOVE1: cond = freq_above_q;
		`FN_FREQ_ABOVE2: cond = freq_above_q;
		`FN_STO: cond = safe_torque_off_state;
		`FN_NO_ALARM: cond = !alarm_present;
		`FN_NO_FAULT_ALARM: cond = !any_fault && !alarm_present;
		default: cond = 1'b0;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Output registers, re-evaluated every cycle from the live selectors.

reg [4:0] out_q;
reg [4:0] out_d;
integer i;

always @* begin
	out_d = 5'b00000;
	for (i = 0; i < 5; i = i + 1) begin
		out_d[i] = cond(func_sel[i*6 +: 6],
			(i == 1) ? r2_q : r3_q,
			(i == 1) || (i == 2),
			network_output_word[i]);
	end
end

always @(posedge clk or negedge rstn) begin
	if (!rstn)
		out_q <= 5'b00000;
	else
		out_q <= out_d;
end

assign output_n = out_q;

endmodule
`default_nettype wire

// *** output_properties.sv ***
// Port-level assertions for the output selector, first output only.
`timescale 1ns/1ps
`default_nettype none
`include "output_select_map.vh"
module output_properties (
	input wire clk,
	input wire rstn,
	input wire [29:0] func_sel,
	input wire [2:0] control_type_select,
	input wire [2:0] control_mode_select,
	input wire [15:0] current_threshold,
	input wire [15:0] motor_current,
	input wire [15:0] zero_speed_zone,
	input wire [15:0] motor_speed,
	input wire drive_enabled,
	input wire undervoltage,
	input wire any_fault,
	input wire [4:0] network_output_word,
	input wire [4:0] output_n
);
	wire [5:0] s0;
	wire on0;
	wire ty_ok;
	assign s0 = func_sel[5:0];
	assign on0 = output_n[0];
	assign ty_ok = control_type_select == 3'h3 || control_type_select == 3'h4;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	chk_unused_rest: assert property (s0 == `FN_UNUSED |=> !on0)
		else $error("unused output active");
	chk_cur_compare: assert property (s0 == `FN_CUR_ABOVE
		|=> on0 == $past(motor_current > current_threshold))
		else $error("current compare wrong");
	chk_zero_speed: assert property (s0 == `FN_ZERO_SPEED
		|=> on0 == $past(motor_speed < zero_speed_zone))
		else $error("zero speed wrong");
	chk_torque_gate: assert property (s0 == `FN_TORQ_ABOVE
		&& !ty_ok |=> !on0)
		else $error("torque gate open");
	chk_run_follow: assert property (s0 == `FN_RUN
		|=> on0 == $past(drive_enabled))
		else $error("run wrong");
	chk_ready_block: assert property (s0 == `FN_READY
		&& (drive_enabled || any_fault || undervoltage) |=> !on0)
		else $error("ready while blocked");
	chk_network_bit: assert property (s0 == `FN_NETWORK
		|=> on0 == $past(network_output_word[0]))
		else $error("network bit wrong");
	chk_timer_gate: assert property (s0 == `FN_TIMER |=> !on0)
		else $error("timer on first output");
	chk_sref_gate: assert property (s0 == `FN_SPEED_AND_REF
		&& control_mode_select != 3'h4 |=> !on0)
		else $error("combined speed gate open");
endmodule
bind output_select output_properties u_props (.clk(clk), .rstn(rstn),
	.func_sel(func_sel), .control_type_select(control_type_select),
	.control_mode_select(control_mode_select), .motor_speed(motor_speed),
	.current_threshold(current_threshold), .motor_current(motor_current),
	.zero_speed_zone(zero_speed_zone), .drive_enabled(drive_enabled),
	.undervoltage(undervoltage), .any_fault(any_fault),
	.network_output_word(network_output_word), .output_n(output_n));
`default_nettype wire

// *** load_model.sv ***
// Field load model: relay coils and open-collector transistors.
`timescale 1ns/1ps
`default_nettype none
module load_model (
	input wire logic [4:0] output_n,
	output logic [4:0] coil_on
);
	// Loads hold no state, so a coil is energised exactly while driven.
	assign coil_on = output_n;
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the output selector.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk;
	logic rstn;
	logic [29:0] fs;
	logic [2:0] ty;
	logic [2:0] md;
	logic [15:0] v [0:18];
	logic [11:0] b;
	logic [5:0] fg;
	logic [4:0] net;
	logic [5:0] c;
	logic [1:0] e;
	wire [4:0] output_n;
	wire [4:0] coil_on;
	int failures;
	int cmp_count;
	output_select #(.TICK_CYCLES(4)) u_output_select (.clk(clk), .rstn(rstn),
		.func_sel(fs), .control_type_select(ty), .control_mode_select(md),
		.speed_upper_threshold(v[0]), .speed_lower_threshold(v[1]),
		.speed_hysteresis(v[2]), .zero_speed_zone(v[3]),
		.current_threshold(v[4]), .torque_threshold(v[5]), .at_ref_band(v[6]),
		.freq_threshold(v[7]), .freq_hysteresis(v[8]),
		.relay2_on_delay(v[9]), .relay2_off_delay(v[10]),
		.relay3_on_delay(v[11]), .relay3_off_delay(v[12]),
		.motor_speed(v[13]), .speed_reference(v[14]), .total_reference(v[15]),
		.motor_current(v[16]), .motor_torque_reading(v[17]), .motor_freq(v[18]),
		.motor_reverse(b[0]), .remote_mode(b[1]), .drive_enabled(b[2]),
		.undervoltage(b[3]), .any_fault(b[4]), .fault_groups(fg),
		.alarm_present(b[5]), .loop_current_ok(b[6]), .network_output_word(net),
		.ride_through(b[7]), .precharge_ok(b[8]), .safe_torque_off_state(b[9]),
		.relay2_timer_input(b[10]), .relay3_timer_input(b[11]),
		.output_n(output_n));
	load_model u_load_model (.output_n(output_n), .coil_on(coil_on));
	////////////////////////////////////////////////////////////////////////
	// Expected first-output level; bit 1 clear means the code is not judged.
	function automatic logic [1:0] exp0(input logic [5:0] k);
		logic t;
		t = ty == 3'h3 || ty == 3'h4;
		case (k)
		6'h00, 6'h1D: exp0 = 2'b10;
		6'h05: exp0 = {1'b1, v[13] < v[3]};
		6'h06: exp0 = {1'b1, v[16] > v[4]};
		6'h08: exp0 = {1'b1, t && v[17] > v[5]};
		6'h0A: exp0 = {1'b1, b[1]};
		6'h0B: exp0 = {1'b1, b[2]};
		6'h0C: exp0 = {1'b1, !(b[2] | b[3] | b[4])};
		6'h0D: exp0 = {1'b1, !b[4]};
		6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12:
			exp0 = {1'b1, !fg[k - 6'h0E]};
		6'h13: exp0 = {1'b1, b[6]};
		6'h14: exp0 = {1'b1, net[0]};
		6'h15: exp0 = {1'b1, !b[0]};
		6'h19: exp0 = {1'b1, b[8]};
		6'h1A: exp0 = {1'b1, b[4]};
		6'h22: exp0 = {1'b1, !fg[5]};
		6'h23: exp0 = {1'b1, !b[5]};
		6'h24: exp0 = {1'b1, !(b[4] | b[5])};
		default: exp0 = 2'b00;
		endcase
	endfunction
	task check_bit(input logic x, input logic g);
		cmp_count++;
		if (g !== x) begin
			failures++;
			$display("mismatch at %0t exp %h got %h", $time, x, g);
		end
	endtask
	task check_vec(input logic [4:0] x, input logic [4:0] g);
		cmp_count++;
		if (g !== x) begin
			failures++;
			$display("mismatch at %0t exp %h got %h", $time, x, g);
		end
	endtask
	task hyst(input logic [15:0] s, input logic x);
		@(negedge clk);
		v[13] = s;
		repeat (3) @(negedge clk);
		check_bit(x, output_n[1]);
	endtask
	// Timer edges land on tick boundaries, so the wait is bounded, not fixed.
	task wait_bit(input logic x);
		int n;
		n = 0;
		while (output_n[1] !== x && n < 40) begin
			@(negedge clk);
			n++;
		end
		check_bit(x, output_n[1]);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#30000;
		failures++;
		tally_and_finish();
	end
	initial begin
		rstn = 1'b0;
		fs = 30'h0000_0000;
		ty = 3'h0;
		md = 3'h0;
		b = 12'h000;
		fg = 6'h00;
		net = 5'h00;
		foreach (v[i]) v[i] = 16'h0000;
		void'($urandom(32'h0ff6));
		repeat (12) @(negedge clk);
		check_vec(5'h00, coil_on);
		rstn = 1'b1;
		for (int n = 0; n < 300; n++) begin
			@(negedge clk);
			foreach (v[i]) v[i] = 16'($urandom_range(0, 15));
			b = 12'($urandom);
			fg = 6'($urandom);
			net = 5'($urandom);
			ty = 3'($urandom);
			md = 3'($urandom);
			c = 6'($urandom_range(0, 36));
			fs = {24'($urandom), c};
			e = exp0(c);
			@(negedge clk);
			if (e[1]) check_bit(e[0], output_n[0]);
		end
		fs = 30'h0000_0080;
		v[0] = 16'h03E8;
		v[2] = 16'h0064;
		hyst(16'h0000, 1'b0);
		hyst(16'h03E8, 1'b0);
		hyst(16'h03F2, 1'b1);
		hyst(16'h03B6, 1'b1);
		hyst(16'h037A, 1'b0);
		// Every output under network control follows its own word bit.
		@(negedge clk);
		fs = {5{6'h14}};
		net = 5'($urandom);
		repeat (2) @(negedge clk);
		check_vec(net, output_n);
		// Timer code on outputs without a relay timer must stay at rest.
		fs = {6'h1D, 6'h1D, 6'h00, 6'h00, 6'h1D};
		repeat (2) @(negedge clk);
		check_vec(5'h00, output_n & 5'b11001);
		fs = 30'h0000_0740;
		v[9] = 16'h0003;
		v[10] = 16'h0002;
		b[10] = 1'b0;
		repeat (40) @(negedge clk);
		b[10] = 1'b1;
		repeat (6) @(negedge clk);
		b[10] = 1'b0;
		repeat (6) @(negedge clk);
		check_bit(1'b0, output_n[1]);
		b[10] = 1'b1;
		repeat (9) @(negedge clk);
		check_bit(1'b0, output_n[1]);
		wait_bit(1'b1);
		b[10] = 1'b0;
		repeat (5) @(negedge clk);
		check_bit(1'b1, output_n[1]);
		wait_bit(1'b0);
		rstn = 1'b0;
		@(negedge clk);
		check_vec(5'h00, output_n);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
